// *** shared/pin_ctrl_pkg.sv ***
// shared constants for the port pin control and pin interrupt block
package pin_ctrl_pkg;
	localparam int NUM_PORTS     = 3;
	localparam int PORT_W        = 8;
	localparam int NUM_PINS      = NUM_PORTS * PORT_W;
	localparam int NUM_IRQ_PORTS = 2;
	localparam int IRQ_PINS      = 4;
	localparam int ADDR_W        = 8;

	// register byte offsets; each port owns a block of eight words, five of them used
	localparam logic [7:0] PORT_STRIDE = 8'h20;
	localparam logic [7:0] OFS_DATA    = 8'h00;
	localparam logic [7:0] OFS_DIR     = 8'h04;
	localparam logic [7:0] OFS_PULL    = 8'h08;
	localparam logic [7:0] OFS_SLEW    = 8'h0C;
	localparam logic [7:0] OFS_DRIVE   = 8'h10;
	localparam logic [7:0] OFS_GANG    = 8'h60;
	// pin interrupt blocks for port a and port b
	localparam logic [7:0] IRQ_BASE    = 8'h64;
	localparam logic [7:0] IRQ_STRIDE  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_SC  = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h04;
	localparam logic [7:0] OFS_IRQ_POL = 8'h08;

	// status and control field positions
	localparam int SC_MODE_BIT = 0;
	localparam int SC_IE_BIT   = 1;
	localparam int SC_ACK_BIT  = 2;
	localparam int SC_FLAG_BIT = 3;

	// gang control field positions and the pins they add
	localparam int GANG_EN_BIT  = 0;
	localparam int PIN_C0       = 16;
	localparam int PIN_C1       = 17;
	localparam int PIN_C2       = 18;
	localparam int PIN_C3       = 19;
	localparam int PIN_B2       = 10;
	localparam int PIN_B3       = 11;
	localparam int PIN_B4       = 12;
	localparam int PIN_B5       = 13;
	localparam int GANG_MASTER_PORT = 2;
	localparam int GANG_MASTER_BIT  = 0;

	// reset values
	localparam logic [NUM_PINS-1:0] OE_N_RST  = 24'hFFFFFF;
	localparam logic [IRQ_PINS-1:0] PREV_RST  = 4'hF;
endpackage

// *** logic/pin_irq_port.sv ***
// pin interrupt detector for one port: edge or edge-and-level sensing
module pin_irq_port
	import pin_ctrl_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic [IRQ_PINS-1:0] pin_level,
	input  wire logic [IRQ_PINS-1:0] pin_enable,
	input  wire logic [IRQ_PINS-1:0] polarity,
	input  wire logic                level_mode,
	input  wire logic                irq_enable,
	input  wire logic                ack,
	output logic                     irq_flag,
	output logic                     irq_req
);
	typedef struct packed {
		logic [IRQ_PINS-1:0] prev_asserted;
		logic                flag;
		logic                req;
	} irq_state_t;

	irq_state_t r;
	irq_state_t n;

	// detection, flag set and clear, request gating
	always_comb begin
		logic [IRQ_PINS-1:0] asserted;
		logic [IRQ_PINS-1:0] edge_hit;
		logic                level_hit;
		n = r;
		asserted = pin_level ~^ polarity; // pol 0 means low asserted
		edge_hit = pin_enable & asserted & ~r.prev_asserted; // deasserted then asserted
		// a disabled pin counts as asserted so it must be seen idle first
		n.prev_asserted = (pin_enable & asserted) | ~pin_enable;
		level_hit = level_mode & (|(pin_enable & asserted));
		// set wins over the acknowledge in the same cycle
		n.flag = (r.flag & ~ack) | (|edge_hit) | level_hit;
		n.req = n.flag & irq_enable;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.prev_asserted <= PREV_RST;
		end else begin
			r <= n;
		end
	end

	assign irq_flag = r.flag;
	assign irq_req  = r.req;
endmodule

// *** logic/pin_ctrl_top.sv ***
// port pin control, ganged output and pin interrupts behind an apb slave
//
// per pin: pull enable, slew limit, high drive; three ports of eight pins.
// port a and b pins 3..0 can raise a port interrupt, which is also the wake
// request for low-power modes.

// Contract
// - per-pin pull enable bit turns pull on
// - pull off whenever pin is output
// - pull off while analog function owns pin
// - slew limit bit, no effect on inputs
// - drive bit selects high or low drive
// - gang register accepts only one write
// - gang bit map: enable, port b, port c; code has bit 0 enable, bits 3..1 port c, bits 7..4 port b
// - ganged pins output, follow master pin controls
// - gang beats digital peripheral, analog beats gang
// - gang enable forces master pin output
// - port a/b pins 3..0 interrupt and wake
// - one interrupt enable bit per eligible pin
// - per-port mode bit: edge or edge-and-level
// - polarity bit picks edge and level sense
// - edge needs deasserted sighting first, synchronous
// - edge is one sample then opposite sample
// - edge sets flag, enable raises request
// - writing ack one clears flag
// - level mode keeps flag while pin asserted
// - polarity picks pull-up or pull-down on interrupt pins
// - reset: inputs, no slew, low drive, no pulls
module pin_ctrl_top
	import pin_ctrl_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// shared functions on the same clock
	input  wire logic [NUM_PINS-1:0] periph_oe,
	input  wire logic [NUM_PINS-1:0] periph_out,
	input  wire logic [NUM_PINS-1:0] analog_en,
	// pads
	input  wire logic [NUM_PINS-1:0] pad_in,
	output logic      [NUM_PINS-1:0] pad_out,
	output logic      [NUM_PINS-1:0] pad_oe_n,
	output logic      [NUM_PINS-1:0] pull_up_en,
	output logic      [NUM_PINS-1:0] pull_down_en,
	output logic      [NUM_PINS-1:0] slew_limit_en,
	output logic      [NUM_PINS-1:0] high_drive_en,
	// port interrupt and wake requests
	output logic [NUM_IRQ_PORTS-1:0] irq_req
);
	import pin_ctrl_pkg::*;

	// gang register field positions: bits 3..1 add port c pins 1..3, bits 7..4 add port b pins 2..5
	localparam int GANG_SEL_C1 = 1;
	localparam int GANG_SEL_C2 = 2;
	localparam int GANG_SEL_C3 = 3;
	localparam int GANG_SEL_B2 = 4;
	localparam int GANG_SEL_B3 = 5;
	localparam int GANG_SEL_B4 = 6;
	localparam int GANG_SEL_B5 = 7;

	typedef struct packed {
		// software-visible port registers
		logic [NUM_PORTS-1:0][PORT_W-1:0]       data;
		logic [NUM_PORTS-1:0][PORT_W-1:0]       pin_direction_bit;
		logic [NUM_PORTS-1:0][PORT_W-1:0]       pull_enable_bit;
		logic [NUM_PORTS-1:0][PORT_W-1:0]       slew_limit_bit;
		logic [NUM_PORTS-1:0][PORT_W-1:0]       high_drive_bit;
		// write-once gang setting
		logic [PORT_W-1:0]                      gang_output_control;
		logic                                   gang_written;
		// pin interrupt setup of ports a and b
		logic [NUM_IRQ_PORTS-1:0]               detect_mode_select;
		logic [NUM_IRQ_PORTS-1:0]               port_irq_enable;
		logic [NUM_IRQ_PORTS-1:0][IRQ_PINS-1:0] pin_irq_enable_bit;
		logic [NUM_IRQ_PORTS-1:0][IRQ_PINS-1:0] pin_polarity_bit;
		// pad synchroniser and filtered level
		logic [NUM_PINS-1:0]                    sync1;
		logic [NUM_PINS-1:0]                    sync2;
		logic [NUM_PINS-1:0]                    sync3;
		logic [NUM_PINS-1:0]                    pin_level;
		// registered bus answer
		logic [31:0]                            prdata;
		logic                                   pready;
		logic                                   pslverr;
		// registered pad controls
		logic [NUM_PINS-1:0]                    pad_out;
		logic [NUM_PINS-1:0]                    pad_oe_n;
		logic [NUM_PINS-1:0]                    pull_up;
		logic [NUM_PINS-1:0]                    pull_down;
		logic [NUM_PINS-1:0]                    slew;
		logic [NUM_PINS-1:0]                    hdrive;
	} top_state_t;

	top_state_t                r;
	top_state_t                n;
	logic [NUM_IRQ_PORTS-1:0]  ack_pulse;
	logic [NUM_IRQ_PORTS-1:0]  irq_flag;
	logic [NUM_IRQ_PORTS-1:0]  irq_req_w;

	// expand the gang register into a per-pin membership mask
	function automatic logic [NUM_PINS-1:0] gang_mask(input logic [PORT_W-1:0] g);
		logic [NUM_PINS-1:0] m;
		m = '0;
		m[PIN_C0] = 1'b1; // master pin takes part whenever the gang is enabled
		m[PIN_C1] = g[GANG_SEL_C1];
		m[PIN_C2] = g[GANG_SEL_C2];
		m[PIN_C3] = g[GANG_SEL_C3];
		m[PIN_B2] = g[GANG_SEL_B2]; // bit 4 adds b2, bit 7 adds b5
		m[PIN_B3] = g[GANG_SEL_B3];
		m[PIN_B4] = g[GANG_SEL_B4];
		m[PIN_B5] = g[GANG_SEL_B5];
		// nothing joins while the enable bit is clear
		return g[GANG_EN_BIT] ? m : '0;
	endfunction

	// bus decode, register writes, pin synchronisers and pin output control
	always_comb begin
		logic [31:0]         rd;
		logic                hit;
		logic                wr;
		logic                setup;
		logic [7:0]          base;
		logic [NUM_PINS-1:0] gm;
		logic [NUM_PINS-1:0] pd_sel;
		logic                drv;
		logic                outval;
		logic                pull_on;
		logic                master_slew;
		logic                master_drive;
		int                  i;
		logic [NUM_PINS-1:0] agree;
		n = r;
		// defaults so every path of this process assigns every scratch value
		base = '0;
		gm = '0;
		pd_sel = '0;
		drv = 1'b0;
		outval = 1'b0;
		pull_on = 1'b0;
		master_slew = 1'b0;
		master_drive = 1'b0;
		i = 0;
		agree = '0;
		rd = '0;
		hit = 1'b0;
		ack_pulse = '0;
		setup = psel & ~penable;
		wr = psel & penable & r.pready & pwrite;

		// pad inputs: three stages, a change counts once stages two and three agree
		n.sync1 = pad_in;
		n.sync2 = r.sync1;
		n.sync3 = r.sync2;
		agree = ~(r.sync2 ^ r.sync3);
		n.pin_level = (r.sync2 & agree) | (r.pin_level & ~agree);

		// per-port control registers
		for (int p = 0; p < NUM_PORTS; p++) begin
			base = 8'(p * PORT_STRIDE);
			// port data latch
			if (paddr == base + OFS_DATA) begin
				hit = 1'b1;
				// outputs read the latch; inputs read the pad, zero under analog
				for (int b = 0; b < PORT_W; b++) begin
					i = p * PORT_W + b;
					rd[b] = r.pin_direction_bit[p][b] ? r.data[p][b] : (r.pin_level[i] & ~analog_en[i]);
				end
				if (wr) n.data[p] = pwdata[PORT_W-1:0];
			end

			// direction: a set bit drives the pin
			if (paddr == base + OFS_DIR) begin
				hit = 1'b1;
				rd[PORT_W-1:0] = r.pin_direction_bit[p];
				if (wr) n.pin_direction_bit[p] = pwdata[PORT_W-1:0];
			end

			// pull device enables
			if (paddr == base + OFS_PULL) begin
				hit = 1'b1;
				rd[PORT_W-1:0] = r.pull_enable_bit[p];
				if (wr) n.pull_enable_bit[p] = pwdata[PORT_W-1:0];
			end

			// slew limit enables
			if (paddr == base + OFS_SLEW) begin
				hit = 1'b1;
				rd[PORT_W-1:0] = r.slew_limit_bit[p];
				if (wr) n.slew_limit_bit[p] = pwdata[PORT_W-1:0];
			end

			// high drive enables
			if (paddr == base + OFS_DRIVE) begin
				hit = 1'b1;
				rd[PORT_W-1:0] = r.high_drive_bit[p];
				if (wr) n.high_drive_bit[p] = pwdata[PORT_W-1:0];
			end
		end

		// gang control: the first write sticks until reset
		if (paddr == OFS_GANG) begin
			hit = 1'b1;
			rd[PORT_W-1:0] = r.gang_output_control;
			// a second write leaves the stored setting alone
			if (wr && !r.gang_written) begin
				n.gang_output_control = pwdata[PORT_W-1:0];
				n.gang_written = 1'b1;
			end
		end

		// pin interrupt registers of port a and port b
		for (int q = 0; q < NUM_IRQ_PORTS; q++) begin
			base = 8'(IRQ_BASE + q * IRQ_STRIDE);
			// mode, enable, write-one acknowledge and flag
			if (paddr == base + OFS_IRQ_SC) begin
				hit = 1'b1;
				rd[SC_MODE_BIT] = r.detect_mode_select[q];
				rd[SC_IE_BIT] = r.port_irq_enable[q];
				rd[SC_FLAG_BIT] = irq_flag[q];
				if (wr) begin
					n.detect_mode_select[q] = pwdata[SC_MODE_BIT];
					n.port_irq_enable[q] = pwdata[SC_IE_BIT];
					ack_pulse[q] = pwdata[SC_ACK_BIT]; // write one acknowledges
				end
			end

			// per-pin interrupt enables
			if (paddr == base + OFS_IRQ_EN) begin
				hit = 1'b1;
				rd[IRQ_PINS-1:0] = r.pin_irq_enable_bit[q];
				if (wr) n.pin_irq_enable_bit[q] = pwdata[IRQ_PINS-1:0];
			end

			// per-pin polarity
			if (paddr == base + OFS_IRQ_POL) begin
				hit = 1'b1;
				rd[IRQ_PINS-1:0] = r.pin_polarity_bit[q];
				if (wr) n.pin_polarity_bit[q] = pwdata[IRQ_PINS-1:0];
			end
		end

		// answer is prepared during setup so pready and prdata come from flops
		n.pready = setup;
		// read data and error are captured from the setup cycle
		if (setup) begin
			n.prdata = rd;
			n.pslverr = ~hit;
		end else begin
			n.pslverr = 1'b0;
		end

		// interrupt pins whose polarity turns the pull device into a pull-down
		pd_sel = '0;
		for (int q = 0; q < NUM_IRQ_PORTS; q++) begin
			for (int b = 0; b < IRQ_PINS; b++) begin
				pd_sel[q * PORT_W + b] = r.pin_irq_enable_bit[q][b] & r.pin_polarity_bit[q][b];
			end
		end

		// per-pin output, pull, slew and drive control
		gm = gang_mask(r.gang_output_control);
		master_slew = r.slew_limit_bit[GANG_MASTER_PORT][GANG_MASTER_BIT];
		master_drive = r.high_drive_bit[GANG_MASTER_PORT][GANG_MASTER_BIT];
		for (int p = 0; p < NUM_PORTS; p++) begin
			for (int b = 0; b < PORT_W; b++) begin
				i = p * PORT_W + b;
				// analog wins, then gang, then peripheral, then direction bit
				drv = ~analog_en[i] & (gm[i] | periph_oe[i] | r.pin_direction_bit[p][b]);
				if (gm[i]) begin
					outval = r.data[GANG_MASTER_PORT][GANG_MASTER_BIT];
				end else if (periph_oe[i]) begin
					outval = periph_out[i];
				end else begin
					outval = r.data[p][b];
				end
				// pad data is held low while the pin floats
				n.pad_out[i] = drv & outval;
				n.pad_oe_n[i] = ~drv;

				// pull device, pull-down only on enabled interrupt pins
				pull_on = r.pull_enable_bit[p][b] & ~drv & ~analog_en[i];
				n.pull_up[i] = pull_on & ~pd_sel[i];
				n.pull_down[i] = pull_on & pd_sel[i];

				// slew and drive only matter on a driven pin
				n.slew[i] = drv & (gm[i] ? master_slew : r.slew_limit_bit[p][b]);
				n.hdrive[i] = drv & (gm[i] ? master_drive : r.high_drive_bit[p][b]);
			end
		end
	end

	// all state; reset leaves every pin an input with no pull, slew or drive
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.pad_oe_n <= OE_N_RST;
		end else begin
			r <= n;
		end
	end

	// one detector per interrupt-capable port
	generate
		for (genvar q = 0; q < NUM_IRQ_PORTS; q++) begin : g_irq
			// the detector sees the filtered level of pins 3..0
			pin_irq_port u_irq (
				.ref_clk    (ref_clk),
				.rst        (rst),
				.pin_level  (r.pin_level[q * PORT_W +: IRQ_PINS]),
				.pin_enable (r.pin_irq_enable_bit[q]),
				.polarity   (r.pin_polarity_bit[q]),
				.level_mode (r.detect_mode_select[q]),
				.irq_enable (r.port_irq_enable[q]),
				.ack        (ack_pulse[q]),
				.irq_flag   (irq_flag[q]),
				.irq_req    (irq_req_w[q])
			);
		end
	endgenerate

	// apb answer, straight from flops
	assign prdata        = r.prdata;
	assign pready        = r.pready;
	assign pslverr       = r.pslverr;

	// pad controls, straight from flops
	assign pad_out       = r.pad_out;
	assign pad_oe_n      = r.pad_oe_n;
	assign pull_up_en    = r.pull_up;
	assign pull_down_en  = r.pull_down;
	assign slew_limit_en = r.slew;
	assign high_drive_en = r.hdrive;

	// interrupt and wake requests, flops inside the detectors
	assign irq_req       = irq_req_w;
endmodule

// *** sim/pin_world.sv ***
// far-side model: external circuitry hanging on the port pins
module pin_world
	import pin_ctrl_pkg::*;
(
	input	wire logic			ref_clk,
	input	wire logic [NUM_PINS-1:0]	pad_out,
	input	wire logic [NUM_PINS-1:0]	pad_oe_n,
	input	wire logic [NUM_PINS-1:0]	pull_up_en,
	input	wire logic [NUM_PINS-1:0]	pull_down_en,
	input	wire logic [NUM_PINS-1:0]	ext_oe,
	input	wire logic [NUM_PINS-1:0]	ext_val,
	output	logic [NUM_PINS-1:0]		pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NUM_PINS-1:0]	float_reg = '0;
	// an undriven pin with no pull wanders, so flip it every cycle
	always_ff @(posedge ref_clk) float_reg <= ~float_reg;
	// device drive wins, then the outside driver, then the pull devices
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_oe & ext_val)
		| (pad_oe_n & ~ext_oe & (pull_up_en | (~pull_down_en & float_reg)));
endmodule

// *** sim/pin_ctrl_asserts.sv ***
// concurrent checks on the pin control block's ports
module pin_ctrl_asserts
	import pin_ctrl_pkg::*;
(
	input	wire logic			ref_clk,
	input	wire logic			rst,
	input	wire logic			pslverr,
	input	wire logic [NUM_PINS-1:0]	analog_en,
	input	wire logic [NUM_PINS-1:0]	pad_oe_n,
	input	wire logic [NUM_PINS-1:0]	pull_up_en,
	input	wire logic [NUM_PINS-1:0]	pull_down_en,
	input	wire logic [NUM_PINS-1:0]	slew_limit_en,
	input	wire logic [NUM_PINS-1:0]	high_drive_en,
	input	wire logic [NUM_IRQ_PORTS-1:0]	irq_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// pull devices stay off on driven pins
	a_pull_off_out: assert property ((pull_up_en & ~pad_oe_n) == '0)
		else $error("pull up on a driven pin");
	a_pulldn_off_out: assert property ((pull_down_en & ~pad_oe_n) == '0)
		else $error("pull down on a driven pin");
	// analog ownership clears pulls on the next cycle, and the drive of pin b2
	a_pull_off_analog: assert property (((pull_up_en | pull_down_en) & $past(analog_en)) == '0)
		else $error("pull on an analog pin");
	a_analog_no_drive: assert property (analog_en[PIN_B2] |=> pad_oe_n[PIN_B2] && !pull_up_en[PIN_B2])
		else $error("analog pin still driven");
	// slew and drive settings only reach driven pins
	a_slew_inputs: assert property ((slew_limit_en & pad_oe_n) == '0)
		else $error("slew limit on an input");
	a_drive_inputs: assert property ((high_drive_en & pad_oe_n) == '0)
		else $error("high drive on an input");
	// pull down only on interrupt pins, and on pin 0 never with pull up
	a_pulldn_pins: assert property ((pull_down_en & ~24'h000F0F) == '0)
		else $error("pull down off the interrupt pins");
	a_pulls_apart: assert property (pull_down_en[0] |-> !pull_up_en[0])
		else $error("both pulls on");
	c_irq: cover property (irq_req[0]);
	c_pulldn: cover property (pull_down_en[0]);
	c_gang: cover property (!pad_oe_n[PIN_B5]);
	c_err: cover property (pslverr);
endmodule
bind pin_ctrl_top pin_ctrl_asserts chk (.ref_clk, .rst, .pslverr, .analog_en, .pad_oe_n, .pull_up_en,
	.pull_down_en, .slew_limit_en, .high_drive_en, .irq_req);

// *** sim/port_pin_control_and_pin_interrupts_test.sv ***
// self-checking bench: random pin setups, gang register, pin interrupts
module port_pin_control_and_pin_interrupts_test
	import pin_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic	ref_clk = 1'b0;
	logic	rst = 1'b1;
	logic	psel = 1'b0;
	logic	penable = 1'b0;
	logic	pwrite = 1'b0;
	logic	[ADDR_W-1:0] paddr = '0;
	logic	[31:0] pwdata = '0;
	logic	[31:0] prdata, rd;
	logic	pready, pslverr, er;
	logic	[NUM_PINS-1:0] periph_oe = '0, periph_out = '0, analog_en = '0, ext_oe = '0, ext_val = '0;
	logic	[NUM_PINS-1:0] pad_in, pad_out, pad_oe_n, pull_up_en, pull_down_en, slew_limit_en, high_drive_en;
	logic	[NUM_IRQ_PORTS-1:0] irq_req;
	logic	[NUM_PINS-1:0] regs [5] = '{default: '0};
	logic	[7:0] g = '0;
	int	bad_count = 0;
	int	num_checks = 0;

	pin_ctrl_top uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.periph_oe, .periph_out, .analog_en, .pad_in, .pad_out, .pad_oe_n, .pull_up_en, .pull_down_en,
		.slew_limit_en, .high_drive_en, .irq_req);
	pin_world far (.ref_clk, .pad_out, .pad_oe_n, .pull_up_en, .pull_down_en, .ext_oe, .ext_val, .pad_in);

	// 125 MHz clock
	initial forever #4 ref_clk = ~ref_clk;

	task automatic report_and_stop();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [NUM_PINS-1:0] exp, input logic [NUM_PINS-1:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer, then an idle cycle
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
		if (n >= 16) begin
			bad_count++;
			report_and_stop();
		end
	endtask

	// expected pad controls from registers, gang setting and shared functions
	task automatic check_pins();
		logic [NUM_PINS-1:0] gm, dv, src, sl, hd;
		gm = {4'h0, g[3:1], 1'b1, 2'b0, g[7:4], 10'h0} & {NUM_PINS{g[GANG_EN_BIT]}};
		dv = (regs[1] | periph_oe | gm) & ~analog_en;
		src = (gm & {NUM_PINS{regs[0][PIN_C0]}}) | (~gm & periph_oe & periph_out) | (~gm & ~periph_oe & regs[0]);
		sl = (gm & {NUM_PINS{regs[3][PIN_C0]}}) | (~gm & regs[3]);
		hd = (gm & {NUM_PINS{regs[4][PIN_C0]}}) | (~gm & regs[4]);
		cmp("pad_oe_n", ~dv, pad_oe_n);
		cmp("pad_out", dv & src, pad_out);
		cmp("pull_up_en", regs[2] & ~dv & ~analog_en, pull_up_en);
		cmp("slew_limit_en", dv & sl, slew_limit_en);
		cmp("high_drive_en", dv & hd, high_drive_en);
	endtask

	// main sequence
	initial begin
		void'($urandom(32'h9E5C));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		check_pins();
		for (int it = 0; it < 24; it++) begin
			if (it == 12) begin
				g = (8'($urandom) & 8'h6E) | 8'h81; // b5 always joins, b2 never
				bus(1'b1, OFS_GANG, 32'(g));
				bus(1'b1, OFS_GANG, 32'(~g));
				bus(1'b0, OFS_GANG, '0);
				cmp("gang_output_control", 24'(g), rd[NUM_PINS-1:0]);
			end
			for (int p = 0; p < NUM_PORTS; p++)
				for (int k = 0; k < 5; k++) begin
					regs[k][p*8 +: 8] = (it == 1) ? 8'hFF : 8'($urandom);
					bus(1'b1, 8'(p * 32 + k * 4), 32'(regs[k][p*8 +: 8]));
				end
			bus(1'b0, 8'(it % 3 * 32) + OFS_PULL, '0);
			cmp("pull readback", 24'(regs[2][it % 3 * 8 +: 8]), rd[NUM_PINS-1:0]);
			periph_oe <= (it < 2) ? '0 : NUM_PINS'($urandom);
			periph_out <= NUM_PINS'($urandom);
			analog_en <= NUM_PINS'($urandom & $urandom);
			ext_oe <= NUM_PINS'($urandom);
			ext_val <= NUM_PINS'($urandom);
			repeat (2) @(posedge ref_clk);
			check_pins();
		end
		bus(1'b0, 8'hFC, '0);
		cmp("pslverr", 24'h1, 24'(er));
		cmp("unmapped prdata", '0, rd[NUM_PINS-1:0]);
		// pin 0 of port a, then of port b, as interrupt input, every polarity and mode
		periph_oe <= '0;
		analog_en <= '0;
		for (int x = 0; x < NUM_IRQ_PORTS; x++) begin
			logic [ADDR_W-1:0] ia;
			int pn;
			ia = 8'(IRQ_BASE + x * IRQ_STRIDE);
			pn = x * PORT_W;
			ext_oe[pn] <= 1'b1;
			bus(1'b1, 8'(x * 32) + OFS_DIR, '0);
			bus(1'b1, 8'(x * 32) + OFS_PULL, 32'h1);
			for (int m = 0; m < 4; m++) begin
				bus(1'b1, ia + OFS_IRQ_EN, '0);
				ext_val[pn] <= m[0];
				bus(1'b1, ia + OFS_IRQ_POL, 32'(m[0]));
				bus(1'b1, ia + OFS_IRQ_EN, 32'h1);
				repeat (8) @(posedge ref_clk);
				bus(1'b1, ia, 32'(m[1]) | 32'h4);
				bus(1'b1, ia, 32'(m[1]) | 32'h2);
				repeat (8) @(posedge ref_clk);
				if (!m[1]) cmp("irq_req", '0, 24'(irq_req[x]));
				cmp("pull_down_en", 24'(m[0]), 24'(pull_down_en[pn]));
				cmp("pull_up_en", 24'(!m[0]), 24'(pull_up_en[pn]));
				ext_val[pn] <= !m[0];
				repeat (8) @(posedge ref_clk);
				bus(1'b1, ia, 32'(m[1]) | 32'h6);
				repeat (2) @(posedge ref_clk);
				cmp("irq_req", '0, 24'(irq_req[x]));
				ext_val[pn] <= m[0];
				for (int n = 0; n < 12 && irq_req[x] !== 1'b1; n++) @(posedge ref_clk);
				cmp("irq_req", 24'h1, 24'(irq_req[x]));
				if (irq_req[x] !== 1'b1) report_and_stop();
				bus(1'b0, ia, '0);
				cmp("port_irq_flag", 24'h1, 24'(rd[SC_FLAG_BIT]));
				bus(1'b1, ia, 32'(m[1]) | 32'h6);
				repeat (2) @(posedge ref_clk);
				cmp("irq_req", 24'(m[1]), 24'(irq_req[x]));
			end
		end
		report_and_stop();
	end
endmodule
